// [hw/rced_pkg.sv]
// Purpose: constants and types of the channel equalizer/driver register bank
// Assumes: 8-bit register addresses and data
// Notes: one localparam per offset, field position and reset value
package rced_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_EQ_DRV = 8'h15;
    localparam logic [7:0] ADDR_RSV_A = 8'h16;
    localparam logic [7:0] ADDR_RSV_B = 8'h17;
    localparam logic [7:0] ADDR_DIV_EDGE = 8'h18;
    localparam logic [7:0] ADDR_RSV_C = 8'h19;
    localparam logic [7:0] ADDR_RSV_D = 8'h1A;
    localparam logic [7:0] ADDR_RSV_E = 8'h1B;
    localparam logic [7:0] ADDR_RSV_F = 8'h1C;
    localparam logic [7:0] ADDR_RSV_G = 8'h1D;
    localparam logic [7:0] ADDR_SRC_SEL = 8'h1E;
    localparam logic [7:0] ADDR_DRV_POL = 8'h1F;
    localparam int NUM_REGS = 11;

    // Reset values
    localparam logic [7:0] RST_EQ_DRV = 8'h10;
    localparam logic [7:0] RST_RSV_A = 8'h7A;
    localparam logic [7:0] RST_RSV_B = 8'h25;
    localparam logic [7:0] RST_DIV_EDGE = 8'h40;
    localparam logic [7:0] RST_RSV_C = 8'h23;
    localparam logic [7:0] RST_RSV_D = 8'h00;
    localparam logic [7:0] RST_RSV_E = 8'h03;
    localparam logic [7:0] RST_RSV_F = 8'h24;
    localparam logic [7:0] RST_RSV_G = 8'h00;
    localparam logic [7:0] RST_SRC_SEL = 8'hE1;
    localparam logic [7:0] RST_DRV_POL = 8'h55;
    localparam logic [7:0] RST_VALS [NUM_REGS] = '{RST_EQ_DRV, RST_RSV_A,
        RST_RSV_B, RST_DIV_EDGE, RST_RSV_C, RST_RSV_D, RST_RSV_E,
        RST_RSV_F, RST_RSV_G, RST_SRC_SEL, RST_DRV_POL};

    // Array index of each steering register
    localparam logic [3:0] IDX_EQ_DRV = 4'(ADDR_EQ_DRV - ADDR_EQ_DRV);
    localparam logic [3:0] IDX_DIV_EDGE = 4'(ADDR_DIV_EDGE - ADDR_EQ_DRV);
    localparam logic [3:0] IDX_SRC_SEL = 4'(ADDR_SRC_SEL - ADDR_EQ_DRV);
    localparam logic [3:0] IDX_DRV_POL = 4'(ADDR_DRV_POL - ADDR_EQ_DRV);

    // Field positions
    localparam int EQ_MANUAL_BIT = 7;
    localparam int COMPRESS_BIT = 6;
    localparam int PWDN_BIT = 3;
    localparam int DEEMPH_LSB = 0;
    localparam int DIV_LSB = 4;
    localparam int SLOW_EDGE_BIT = 2;
    localparam int SRC_LSB = 5;
    localparam int PRBS_SER_BIT = 4;
    localparam int EQ_DIS_BIT = 3;
    localparam int INV_BIT = 7;

    // De-emphasis span in dB, normal and compressed
    localparam int DEEMPH_MAX_DB = 12;
    localparam int DEEMPH_COMP_MAX_DB = 6;

    localparam logic [2:0] DIV_POWERUP = 3'h4;

    typedef enum logic [2:0] {
        SRC_RAW = 3'h0,
        SRC_RETIMED = 3'h1,
        SRC_PRBS = 3'h4,
        SRC_MUTE = 3'h7
    } rced_src_t;

    typedef enum logic [2:0] {
        PRBS_IDLE = 3'b001,
        PRBS_ARMED = 3'b010,
        PRBS_RUN = 3'b100
    } rced_prbs_t;

endpackage

// [hw/rced_field_if.sv]
// Purpose: carries register contents from the bank to the control decoder
// Assumes: single clock domain
// Notes: bank drives every signal, decoder only reads
`timescale 1ns/1ps
interface rced_field_if;
    logic [7:0] eq_drv;
    logic [7:0] div_edge;
    logic [7:0] src_sel;
    logic [7:0] drv_pol;
    logic div_ratio_en;
    logic prbs_shift_en;
    logic [3:0] prbs_cfg;

    modport bank (
        output eq_drv, div_edge, src_sel, drv_pol,
        output div_ratio_en, prbs_shift_en, prbs_cfg
    );
    modport decode (
        input eq_drv, div_edge, src_sel, drv_pol,
        input div_ratio_en, prbs_shift_en, prbs_cfg
    );
endinterface

// [hw/rced_ctl_decode.sv]
// Purpose: turns register fields into registered channel controls
// Assumes: fields arrive through rced_field_if, clock enable freezes state
// Notes: undefined source codes are treated as mute
`timescale 1ns/1ps
module rced_ctl_decode
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Register fields
    rced_field_if.decode f,
    // Channel controls
    output logic feedback_equalizer_on,
    output logic feedback_equalizer_manual,
    output logic [2:0] deemph_level,
    output logic deemph_compress,
    output logic driver_power_down,
    output logic [2:0] recovery_oscillator_div,
    output logic slow_edge_rate,
    output rced_pkg::rced_src_t phase_detector_input_sel,
    output logic prbs_serializer_en,
    output logic [3:0] prbs_pattern,
    output logic prbs_running,
    output logic driver_invert
);
    import rced_pkg::*;

    rced_prbs_t prbs_state;
    rced_prbs_t next_prbs_state;
    logic prbs_armed;

    function automatic rced_src_t decode_src(input logic [2:0] code);
        rced_src_t s;
        s = SRC_MUTE;
        case (code)
            3'h0: s = SRC_RAW;
            3'h1: s = SRC_RETIMED;
            3'h4: s = SRC_PRBS;
            default: s = SRC_MUTE;
        endcase
        return s;
    endfunction

    // Equalizer mode
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            feedback_equalizer_on <= !RST_SRC_SEL[EQ_DIS_BIT];
            feedback_equalizer_manual <= RST_EQ_DRV[EQ_MANUAL_BIT];
        end
        else if (clk_en)
        begin
            feedback_equalizer_on <= !f.src_sel[EQ_DIS_BIT];
            feedback_equalizer_manual <= f.eq_drv[EQ_MANUAL_BIT];
        end
    end

    // Transmit driver
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            deemph_level <= RST_EQ_DRV[DEEMPH_LSB +: 3];
            deemph_compress <= RST_EQ_DRV[COMPRESS_BIT];
            driver_power_down <= RST_EQ_DRV[PWDN_BIT];
            slow_edge_rate <= RST_DIV_EDGE[SLOW_EDGE_BIT];
            driver_invert <= RST_DRV_POL[INV_BIT];
        end
        else if (clk_en)
        begin
            deemph_level <= f.eq_drv[DEEMPH_LSB +: 3];
            deemph_compress <= f.eq_drv[COMPRESS_BIT];
            driver_power_down <= f.eq_drv[PWDN_BIT];
            slow_edge_rate <= f.div_edge[SLOW_EDGE_BIT];
            driver_invert <= f.drv_pol[INV_BIT];
        end
    end

    // Oscillator divider, power-up ratio whenever the field is not enabled
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            recovery_oscillator_div <= DIV_POWERUP;
        else if (clk_en)
            recovery_oscillator_div <= f.div_ratio_en ?
                f.div_edge[DIV_LSB +: 3] : DIV_POWERUP;
    end

    // Phase detector source and pattern setup
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_detector_input_sel <= SRC_MUTE;
            prbs_serializer_en <= RST_SRC_SEL[PRBS_SER_BIT];
            prbs_pattern <= 4'h0;
        end
        else if (clk_en)
        begin
            phase_detector_input_sel <= decode_src(f.src_sel[SRC_LSB +: 3]);
            prbs_serializer_en <= f.src_sel[PRBS_SER_BIT];
            prbs_pattern <= f.prbs_cfg;
        end
    end

    // Pattern runs only when shift is raised after setup is complete
    assign prbs_armed = f.src_sel[PRBS_SER_BIT] &&
        (f.src_sel[SRC_LSB +: 3] == SRC_PRBS);

    always_comb
    begin
        next_prbs_state = prbs_state;
        case (prbs_state)
            PRBS_IDLE:
                if (prbs_armed && !f.prbs_shift_en)
                    next_prbs_state = PRBS_ARMED;
            PRBS_ARMED:
                if (!prbs_armed)
                    next_prbs_state = PRBS_IDLE;
                else if (f.prbs_shift_en)
                    next_prbs_state = PRBS_RUN;
            PRBS_RUN:
                if (!prbs_armed || !f.prbs_shift_en)
                    next_prbs_state = PRBS_IDLE;
            default:
                next_prbs_state = PRBS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            prbs_state <= PRBS_IDLE;
        else if (clk_en)
            prbs_state <= next_prbs_state;
    end

    assign prbs_running = (prbs_state == PRBS_RUN);

    property p_prbs_needs_setup;
        @(posedge ref_clk) disable iff (!arst_n)
        prbs_running |-> prbs_serializer_en &&
            phase_detector_input_sel == SRC_PRBS;
    endproperty
    a_prbs_needs_setup: assert property (p_prbs_needs_setup)
        else $error("pattern runs without serializer or source");

    property p_shift_first_blocks;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && prbs_state == PRBS_IDLE && f.prbs_shift_en)
            |=> prbs_state == PRBS_IDLE;
    endproperty
    a_shift_first_blocks: assert property (p_shift_first_blocks)
        else $error("pattern started with shift raised before setup");

endmodule

// [hw/rced_regs.sv]
// Purpose: channel equalizer and driver control register bank
// Assumes: register port synchronous to ref_clk, one access per cycle
// Notes: reserved bits store and return whatever software writes
// Summary of operation
// - Bit 7 of the equalizer/driver register puts the equalizer on software taps.
// - Bit 6 of that register compresses de-emphasis to a 0 to 6 dB span.
// - Bits 2:0 of that register set de-emphasis 0 to 12 dB, reset 000.
// - Bits 6:4 of the divider register set the ratio only when enabled.
// - Bit 2 of the divider register selects the slow driver edge rate.
// - Bits 7:5 of the source register pick raw, retimed, PRBS or mute, reset mute.
// - Bit 4 of the source register enables the PRBS serializer.
// - Bit 3 of the source register set to 1 disables the equalizer.
// - Bit 7 of the polarity register inverts the driver output, reset off.
`timescale 1ns/1ps
module rced_regs
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Register access
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    output logic reg_hit,
    // Bits held in neighbouring channel registers
    input wire logic div_ratio_en,
    input wire logic prbs_shift_en,
    input wire logic [3:0] prbs_pattern_cfg,
    // Channel controls
    output logic feedback_equalizer_on,
    output logic feedback_equalizer_manual,
    output logic [2:0] deemph_level,
    output logic deemph_compress,
    output logic driver_power_down,
    output logic [2:0] recovery_oscillator_div,
    output logic slow_edge_rate,
    output rced_pkg::rced_src_t phase_detector_input_sel,
    output logic prbs_serializer_en,
    output logic [3:0] prbs_pattern,
    output logic prbs_running,
    output logic driver_invert
);
    import rced_pkg::*;

    logic [7:0] regs [NUM_REGS];
    logic [3:0] idx;
    logic hit;

    rced_field_if fields ();

    function automatic logic in_bank(input logic [7:0] a);
        return (a >= ADDR_EQ_DRV) && (a <= ADDR_DRV_POL);
    endfunction

    assign idx = 4'(reg_addr - ADDR_EQ_DRV);
    assign hit = in_bank(reg_addr);

    // Register storage, every bit writable
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs[i] <= RST_VALS[i];
        end
        else if (clk_en && reg_wr && hit)
        begin
            regs[idx] <= reg_wdata;
        end
    end

    // Read data, zero for unmapped addresses
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (clk_en && reg_rd)
            reg_rdata <= hit ? regs[idx] : 8'h00;
    end

    // Access acknowledge and decode result
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_ack <= 1'b0;
            reg_hit <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_ack <= reg_wr || reg_rd;
            reg_hit <= (reg_wr || reg_rd) && hit;
        end
    end

    assign fields.eq_drv = regs[IDX_EQ_DRV];
    assign fields.div_edge = regs[IDX_DIV_EDGE];
    assign fields.src_sel = regs[IDX_SRC_SEL];
    assign fields.drv_pol = regs[IDX_DRV_POL];
    assign fields.div_ratio_en = div_ratio_en;
    assign fields.prbs_shift_en = prbs_shift_en;
    assign fields.prbs_cfg = prbs_pattern_cfg;

    rced_ctl_decode u_decode (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .f(fields),
        .feedback_equalizer_on(feedback_equalizer_on),
        .feedback_equalizer_manual(feedback_equalizer_manual),
        .deemph_level(deemph_level),
        .deemph_compress(deemph_compress),
        .driver_power_down(driver_power_down),
        .recovery_oscillator_div(recovery_oscillator_div),
        .slow_edge_rate(slow_edge_rate),
        .phase_detector_input_sel(phase_detector_input_sel),
        .prbs_serializer_en(prbs_serializer_en),
        .prbs_pattern(prbs_pattern),
        .prbs_running(prbs_running),
        .driver_invert(driver_invert)
    );

    // Write to a register reaches the control two enabled edges later
    property p_manual_follows;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_wr && reg_addr == ADDR_EQ_DRV) ##1 clk_en
            |=> feedback_equalizer_manual == $past(reg_wdata[7], 2);
    endproperty
    a_manual_follows: assert property (p_manual_follows)
        else $error("manual tap control did not follow write");

    property p_compress_follows;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_wr && reg_addr == ADDR_EQ_DRV) ##1 clk_en
            |=> deemph_compress == $past(reg_wdata[6], 2);
    endproperty
    a_compress_follows: assert property (p_compress_follows)
        else $error("de-emphasis compress did not follow write");

    property p_deemph_follows;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_wr && reg_addr == ADDR_EQ_DRV) ##1 clk_en
            |=> deemph_level == $past(reg_wdata[2:0], 2);
    endproperty
    a_deemph_follows: assert property (p_deemph_follows)
        else $error("de-emphasis level did not follow write");

    property p_div_gated;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && !div_ratio_en) |=> recovery_oscillator_div == DIV_POWERUP;
    endproperty
    a_div_gated: assert property (p_div_gated)
        else $error("divider ratio applied without enable");

    property p_div_follows;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_wr && reg_addr == ADDR_DIV_EDGE) ##1
            (clk_en && div_ratio_en)
            |=> recovery_oscillator_div == $past(reg_wdata[6:4], 2);
    endproperty
    a_div_follows: assert property (p_div_follows)
        else $error("divider ratio did not follow write");

    property p_edge_follows;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_wr && reg_addr == ADDR_DIV_EDGE) ##1 clk_en
            |=> slow_edge_rate == $past(reg_wdata[2], 2);
    endproperty
    a_edge_follows: assert property (p_edge_follows)
        else $error("edge rate did not follow write");

    property p_src_prbs;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_wr && reg_addr == ADDR_SRC_SEL &&
            reg_wdata[7:5] == 3'h4) ##1 clk_en
            |=> phase_detector_input_sel == SRC_PRBS;
    endproperty
    a_src_prbs: assert property (p_src_prbs)
        else $error("source select did not become PRBS");

    property p_eq_disable;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_wr && reg_addr == ADDR_SRC_SEL) ##1 clk_en
            |=> feedback_equalizer_on == !$past(reg_wdata[3], 2);
    endproperty
    a_eq_disable: assert property (p_eq_disable)
        else $error("equalizer disable did not follow write");

    property p_invert_follows;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_wr && reg_addr == ADDR_DRV_POL) ##1 clk_en
            |=> driver_invert == $past(reg_wdata[7], 2);
    endproperty
    a_invert_follows: assert property (p_invert_follows)
        else $error("driver invert did not follow write");

    property p_readback;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_wr && !reg_rd && in_bank(reg_addr)) ##1
            (clk_en && reg_rd && !reg_wr &&
            reg_addr == $past(reg_addr))
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_readback: assert property (p_readback)
        else $error("register did not read back written value");

    property p_unmapped;
        @(posedge ref_clk) disable iff (!arst_n)
        (clk_en && reg_rd && !in_bank(reg_addr))
            |=> reg_rdata == 8'h00 && reg_ack && !reg_hit;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned data or hit");

endmodule

// [verification/rced_tb.sv]
// Purpose: self-checking bench for the channel equalizer/driver registers
// Assumes: strobe port with one-cycle answer, inputs driven on falling edge
// Notes: an integer model of the bank predicts every read and control
`timescale 1ns/1ps
module testbench;
    import rced_pkg::*;

    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic div_ratio_en = 1'b0;
    logic prbs_shift_en = 1'b0;
    logic [3:0] prbs_pattern_cfg = 4'h0;
    logic [7:0] reg_rdata;
    logic reg_ack;
    logic reg_hit;
    logic feedback_equalizer_on;
    logic feedback_equalizer_manual;
    logic [2:0] deemph_level;
    logic deemph_compress;
    logic driver_power_down;
    logic [2:0] recovery_oscillator_div;
    logic slow_edge_rate;
    rced_src_t phase_detector_input_sel;
    logic prbs_serializer_en;
    logic [3:0] prbs_pattern;
    logic prbs_running;
    logic driver_invert;
    int mdl [NUM_REGS];
    int exp_run = 0;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] unm [4] = '{8'h00, 8'h14, 8'h20, 8'hFF};

    rced_regs u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_hit(reg_hit), .div_ratio_en(div_ratio_en),
        .prbs_shift_en(prbs_shift_en), .prbs_pattern_cfg(prbs_pattern_cfg),
        .feedback_equalizer_on(feedback_equalizer_on),
        .feedback_equalizer_manual(feedback_equalizer_manual),
        .deemph_level(deemph_level), .deemph_compress(deemph_compress),
        .driver_power_down(driver_power_down),
        .recovery_oscillator_div(recovery_oscillator_div),
        .slow_edge_rate(slow_edge_rate),
        .phase_detector_input_sel(phase_detector_input_sel),
        .prbs_serializer_en(prbs_serializer_en),
        .prbs_pattern(prbs_pattern), .prbs_running(prbs_running),
        .driver_invert(driver_invert));

    always #4 ref_clk = ~ref_clk;

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Far more than the sequence needs; a hang lands in the report
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles >= 5000)
        begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic mapped(input logic [7:0] x);
        return x >= ADDR_EQ_DRV && x <= ADDR_DRV_POL;
    endfunction

    task automatic check_ctl();
        logic [2:0] s;
        logic [2:0] v;
        s = 3'(mdl[9] >> 5);
        if (s != 3'h0 && s != 3'h1 && s != 3'h4)
            s = 3'h7;
        v = div_ratio_en ? 3'(mdl[3] >> 4) : 3'h4;
        chk("manual", 8'(mdl[0][7]), 8'(feedback_equalizer_manual));
        chk("compress", 8'(mdl[0][6]), 8'(deemph_compress));
        chk("deemph", 8'(mdl[0] & 7), 8'(deemph_level));
        chk("pwdn", 8'(mdl[0][3]), 8'(driver_power_down));
        chk("div", 8'(v), 8'(recovery_oscillator_div));
        chk("slow_edge", 8'(mdl[3][2]), 8'(slow_edge_rate));
        chk("src_sel", 8'(s), 8'(phase_detector_input_sel));
        chk("serializer", 8'(mdl[9][4]), 8'(prbs_serializer_en));
        chk("pattern", 8'(prbs_pattern_cfg), 8'(prbs_pattern));
        chk("running", 8'(exp_run), 8'(prbs_running));
        chk("eq_on", 8'(!mdl[9][3]), 8'(feedback_equalizer_on));
        chk("invert", 8'(mdl[10][7]), 8'(driver_invert));
    endtask

    // Entered and left at a falling edge; controls settled on return
    task automatic wr(input logic [7:0] x, input logic [7:0] y);
        reg_addr = x;
        reg_wdata = y;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        reg_wr = 1'b0;
        chk("wr_ack", 8'h01, 8'(reg_ack));
        chk("wr_hit", 8'(mapped(x)), 8'(reg_hit));
        if (mapped(x))
            mdl[x - ADDR_EQ_DRV] = int'(y);
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] x);
        logic [7:0] e;
        e = mapped(x) ? 8'(mdl[x - ADDR_EQ_DRV]) : 8'h00;
        reg_addr = x;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk("rd_data", e, reg_rdata);
        chk("rd_ack", 8'h01, 8'(reg_ack));
        chk("rd_hit", 8'(mapped(x)), 8'(reg_hit));
        @(negedge ref_clk);
    endtask

    task automatic read_all();
        for (int i = 0; i < NUM_REGS; i++)
            rd(8'(int'(ADDR_EQ_DRV) + i));
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        arst_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("rst_ack", 8'h00, 8'(reg_ack));
        arst_n = 1'b1;
        foreach (mdl[i])
            mdl[i] = int'(RST_VALS[i]);
        exp_run = 0;
    endtask

    initial
    begin
        void'($urandom(47770));
        do_reset();
        check_ctl();
        read_all();
        for (int i = 0; i < 40; i++)
        begin
            a = 8'(int'(ADDR_EQ_DRV) + $urandom_range(10, 0));
            d = 8'($urandom);
            div_ratio_en = 1'($urandom);
            prbs_pattern_cfg = 4'($urandom);
            wr(a, d);
            check_ctl();
            rd(a);
        end
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_SRC_SEL, 8'((c << 5) | 'h18));
            check_ctl();
        end
        for (int c = 0; c < 10; c++)
        begin
            div_ratio_en = 1'(c);
            wr(ADDR_DIV_EDGE, 8'(((c / 2) << 4) | ((c % 3) << 2)));
            check_ctl();
        end
        foreach (unm[i])
        begin
            wr(unm[i], 8'hA5);
            rd(unm[i]);
        end
        read_all();
        // Write and read together: read sees the old value
        d = 8'(mdl[1]);
        reg_addr = ADDR_RSV_A;
        reg_wdata = 8'h3C;
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        chk("wr_rd_old", d, reg_rdata);
        mdl[1] = 'h3C;
        @(negedge ref_clk);
        rd(ADDR_RSV_A);
        // Read on the cycle right after a write sees the new value
        d = 8'($urandom);
        reg_addr = ADDR_RSV_C;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        mdl[4] = int'(d);
        @(posedge ref_clk);
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk("wr_rd_next", 8'(mdl[4]), reg_rdata);
        @(negedge ref_clk);
        // Frozen clock enable takes nothing
        clk_en = 1'b0;
        reg_addr = ADDR_RSV_B;
        reg_wdata = 8'hC3;
        reg_wr = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("frozen_ack", 8'h00, 8'(reg_ack));
        reg_wr = 1'b0;
        clk_en = 1'b1;
        @(negedge ref_clk);
        rd(ADDR_RSV_B);
        // Shift raised before setup must not start the pattern
        wr(ADDR_SRC_SEL, RST_SRC_SEL);
        prbs_shift_en = 1'b1;
        wr(ADDR_SRC_SEL, 8'h90);
        repeat (3) @(negedge ref_clk);
        check_ctl();
        prbs_shift_en = 1'b0;
        repeat (2) @(negedge ref_clk);
        prbs_shift_en = 1'b1;
        repeat (3) @(negedge ref_clk);
        exp_run = 1;
        check_ctl();
        prbs_shift_en = 1'b0;
        repeat (2) @(negedge ref_clk);
        exp_run = 0;
        check_ctl();
        prbs_shift_en = 1'b1;
        repeat (3) @(negedge ref_clk);
        exp_run = 1;
        check_ctl();
        wr(ADDR_SRC_SEL, RST_SRC_SEL);
        @(negedge ref_clk);
        exp_run = 0;
        check_ctl();
        prbs_shift_en = 1'b0;
        prbs_pattern_cfg = 4'h0;
        do_reset();
        check_ctl();
        read_all();
        end_sim();
    end
endmodule
